// file: verif/accel_host.sv
/*
  Host model polling the register read port.
  Assumes read data lands one edge after the strobe is taken.
*/
`timescale 1ns/10ps
`default_nettype none

module accel_host (
  // clock
  input wire logic MCLK,
  // read port
  output logic [7:0] RD_ADDR,
  output logic RD_STROBE,
  input wire logic [7:0] RD_DATA
);
  initial begin
    RD_ADDR = 8'h5A;
    RD_STROBE = 1'b0;
  end
  // one-cycle strobe; a cycle gap keeps calls from colliding
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge MCLK);
    RD_STROBE = 1'b1;
    RD_ADDR = a;
    @(negedge MCLK);
    d = RD_DATA;
    RD_STROBE = 1'b0;
    RD_ADDR = ~a; // stale address never lingers
  endtask : rd
endmodule : accel_host

`default_nettype wire

// file: verif/accel_out_chk.sv
/*
  Checks on the read port of the axis output and status block.
  Assumes a bind to that block; it sees the block's ports only.
*/
`timescale 1ns/10ps
`default_nettype none

module accel_out_chk
  import accel_out_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // read port
  input wire logic [7:0] RD_ADDR,
  input wire logic RD_STROBE,
  input wire logic [7:0] RD_DATA,
  // sampler and settings
  input wire logic SAMPLE_VALID,
  input wire accel_out_pkg::sample_set_t SAMPLE_IN,
  input wire logic SAMPLING_ACTIVE,
  input wire logic UNPROCESSED_PASSTHROUGH_SETTING,
  input wire logic [7:0] IRQ_ENABLE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  logic st, pi, nw, craw;
  sample_set_t cap;
  assign st = RD_STROBE && RD_ADDR == 8'h13;
  assign pi = RD_STROBE && RD_ADDR == 8'h14;
  assign nw = SAMPLE_VALID && SAMPLING_ACTIVE;
  // last stored set, so a read at any distance can be judged
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      cap <= '0;
      craw <= 1'b0;
    end else if (nw) begin
      cap <= SAMPLE_IN;
      craw <= UNPROCESSED_PASSTHROUGH_SETTING;
    end
  end
  rsv_bits_a: assert property ((st || pi) |=> RD_DATA[6:5] == 2'h0)
    else $error("reserved bit set");
  new_flag_a: assert property (nw ##1 st |=> RD_DATA[7])
    else $error("new sample flag missing");
  flag_clear_a: assert property (st && !SAMPLE_VALID ##1 !SAMPLE_VALID
    ##1 st |=> !RD_DATA[7]) else $error("flag not cleared");
  sleep_flag_a: assert property (st && !SAMPLE_VALID
    ##1 SAMPLE_VALID && !SAMPLING_ACTIVE ##1 st |=> !RD_DATA[7])
    else $error("flag set while asleep");
  acq_pend_a: assert property (nw && IRQ_ENABLE[7] ##1 pi
    |=> RD_DATA[7]) else $error("sample done not pending");
  pend_clear_a: assert property (pi && IRQ_ENABLE == 8'h00
    ##1 IRQ_ENABLE == 8'h00 ##1 pi |=> RD_DATA == 8'h00)
    else $error("pending not cleared");
  x_low_a: assert property (RD_STROBE && RD_ADDR == 8'h0D && !nw
    |=> RD_DATA == cap.x_axis_sample[7:0]) else $error("x low wrong");
  z_high_a: assert property (RD_STROBE && RD_ADDR == 8'h12 && !nw
    |=> RD_DATA == (craw ? {{2{cap.z_axis_sample[13]}},
    cap.z_axis_sample[13:8]} : cap.z_axis_sample[15:8]))
    else $error("z high wrong");
endmodule : accel_out_chk

bind accel_output_and_event_status accel_out_chk i_chk (
  .MCLK(MCLK), .RSTN(RSTN), .RD_ADDR(RD_ADDR), .RD_STROBE(RD_STROBE),
  .RD_DATA(RD_DATA), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_IN(SAMPLE_IN),
  .SAMPLING_ACTIVE(SAMPLING_ACTIVE), .IRQ_ENABLE(IRQ_ENABLE),
  .UNPROCESSED_PASSTHROUGH_SETTING(UNPROCESSED_PASSTHROUGH_SETTING));

`default_nettype wire

// file: verif/test_accel_output_and_event_status.sv
/*
  Self-checking bench for the axis output and event status block.
  Assumes the host model drives reads at falling edges.
*/
`timescale 1ns/10ps
`default_nettype none

module test_accel_output_and_event_status;
  import accel_out_pkg::*;
  logic mclk, rstn, valid, active, raw, ori, mov, shk, t35, latch, unf;
  logic strobe;
  logic [7:0] addr, rdata, ie, d, ev;
  logic [15:0] m[3];
  sample_set_t smp;
  motion_events_t filt, rawev;
  int error_cnt, check_count, cyc, i, j;

  accel_output_and_event_status i_accel_output_and_event_status (
    .MCLK(mclk), .RSTN(rstn), .RD_ADDR(addr), .RD_STROBE(strobe),
    .RD_DATA(rdata), .SAMPLE_VALID(valid), .SAMPLE_IN(smp),
    .SAMPLING_ACTIVE(active), .EVENTS_FILTERED(filt), .EVENTS_RAW(rawev),
    .UNPROCESSED_PASSTHROUGH_SETTING(raw), .ORIENTATION_DETECT_ON(ori),
    .MOVEMENT_DETECT_ON(mov), .SHAKE_DETECT_ON(shk), .TILT35_DETECT_ON(t35),
    .MOTION_LATCH_ON(latch), .UNFILTERED_FLAG_SELECT(unf), .IRQ_ENABLE(ie));
  accel_host host (.MCLK(mclk), .RD_ADDR(addr), .RD_STROBE(strobe),
    .RD_DATA(rdata));

  // expected live flags and pending arms
  function automatic logic [4:0] live();
    motion_events_t e;
    e = unf ? rawev : filt;
    return e & {t35, shk, mov, ori, ori};
  endfunction : live
  function automatic logic [4:0] arm();
    return live() & ie[4:0] & {mov, mov, 3'h7};
  endfunction : arm

  // one read through the host, compared at once
  task rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    check_count++;
    if (d !== e) begin
      error_cnt++;
      $display("CHECK FAILED reg %h expected %h seen %h", a, e, d);
    end
  endtask : rdc

  task wrap_up();
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    {valid, active, raw, ori, mov, shk, t35, latch, unf} = '0;
    {filt, rawev, ie, smp} = '0;
    rstn = 1'b0;
    void'($urandom(32'h5BA5));
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    for (i = 12; i < 22; i++) rdc(8'(i), 8'h00);
    // samples in both widths; status and pending read in both orders
    active = 1'b1;
    ie = 8'h80;
    for (i = 0; i < 4; i++) begin
      smp = 48'({$urandom, $urandom});
      raw = i[1];
      valid = 1'b1;
      @(negedge mclk);
      valid = 1'b0;
      for (j = 0; j < 3; j++) begin
        m[j] = smp[47 - 16 * j -: 16];
        if (raw) m[j][15:14] = {2{m[j][13]}};
      end
      for (j = 0; j < 4; j++) rdc(8'h13 + 8'((i + j / 2) % 2),
        j % 2 ? 8'h00 : 8'h80);
      for (j = 0; j < 6; j++) rdc(8'(13 + j), m[j / 2][8 * (j % 2) +: 8]);
    end
    // asleep: a sample must not raise the flag or the pending bit
    active = 1'b0;
    rdc(8'h13, 8'h00);
    valid = 1'b1;
    @(negedge mclk);
    valid = 1'b0;
    rdc(8'h13, 8'h00);
    rdc(8'h14, 8'h00);
    active = 1'b1;
    for (i = 0; i < 40; i++) begin
      {ori, mov, shk, t35, unf} = 5'($urandom);
      mov = mov | shk | t35;
      filt = 5'($urandom);
      rawev = 5'($urandom);
      ie = 8'($urandom);
      rdc(8'h13, {3'h0, live()});
      ev = {3'h0, arm()};
      {filt, rawev, ie} = '0;
      rdc(8'h14, ev);
      rdc(8'h14, 8'h00);
    end
    // a one-cycle movement held by the latch, gone once unlatched
    latch = 1'b1;
    {ori, mov, shk, t35, unf} = 5'h08;
    filt = 5'h04;
    @(negedge mclk);
    filt = 5'h00;
    rdc(8'h13, 8'h04);
    latch = 1'b0;
    rdc(8'h13, 8'h00);
    wrap_up();
  end
endmodule : test_accel_output_and_event_status

`default_nettype wire

// file: verilog/accel_out_pkg.sv
/*
  Shared constants and carriers for the axis output and event status block.
  Assumes a register port inside the device that presents a byte address and
  a one-cycle read strobe.
*/
`default_nettype none

package accel_out_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] X_ACCEL_LOW_ADDR = 8'h0D;
  localparam logic [7:0] X_ACCEL_HIGH_ADDR = 8'h0E;
  localparam logic [7:0] Y_ACCEL_LOW_ADDR = 8'h0F;
  localparam logic [7:0] Y_ACCEL_HIGH_ADDR = 8'h10;
  localparam logic [7:0] Z_ACCEL_LOW_ADDR = 8'h11;
  localparam logic [7:0] Z_ACCEL_HIGH_ADDR = 8'h12;
  localparam logic [7:0] MOTION_SAMPLE_FLAGS_ADDR = 8'h13;
  localparam logic [7:0] PENDING_IRQ_FLAGS_ADDR = 8'h14;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int TILT_BIT = 0;
  localparam int FLIP_BIT = 1;
  localparam int MOVE_BIT = 2;
  localparam int SHAKE_BIT = 3;
  localparam int TILT35_BIT = 4;
  localparam int NEW_SAMPLE_BIT = 7;
  localparam int RAW_WIDTH = 14;
  localparam int FULL_WIDTH = 16;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] SAMPLE_RESET = 16'h0000;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // one sample set of three axes
  typedef struct packed {
    logic [15:0] x_axis_sample;
    logic [15:0] y_axis_sample;
    logic [15:0] z_axis_sample;
  } sample_set_t;

  // motion event levels from the detector, bit order as the status fields
  typedef struct packed {
    logic tilt35;
    logic shake;
    logic movement;
    logic flip;
    logic tilt;
  } motion_events_t;

endpackage : accel_out_pkg

`default_nettype wire

// file: verilog/accel_output_and_event_status.sv
/*
  Axis output registers, live motion status and clear-on-read pending status.
  Assumes the detector, sampler and register port all run on MCLK; motion
  control and interrupt enable settings arrive as plain levels.
*/
`timescale 1ns/10ps
`default_nettype none

module accel_output_and_event_status
  import accel_out_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // register read port
  input wire logic [7:0] RD_ADDR,
  input wire logic RD_STROBE,
  output logic [7:0] RD_DATA,
  // sampler side
  input wire logic SAMPLE_VALID,
  input wire accel_out_pkg::sample_set_t SAMPLE_IN,
  input wire logic SAMPLING_ACTIVE,
  // motion detector levels
  input wire accel_out_pkg::motion_events_t EVENTS_FILTERED,
  input wire accel_out_pkg::motion_events_t EVENTS_RAW,
  // settings
  input wire logic UNPROCESSED_PASSTHROUGH_SETTING,
  input wire logic ORIENTATION_DETECT_ON,
  input wire logic MOVEMENT_DETECT_ON,
  input wire logic SHAKE_DETECT_ON,
  input wire logic TILT35_DETECT_ON,
  input wire logic MOTION_LATCH_ON,
  input wire logic UNFILTERED_FLAG_SELECT,
  input wire logic [7:0] IRQ_ENABLE
);

  import accel_out_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // keep the low RAW_WIDTH bits and sign extend them
  function automatic logic [15:0] to_raw_width(input logic [15:0] v);
    to_raw_width = {{(FULL_WIDTH - RAW_WIDTH){v[RAW_WIDTH - 1]}},
                    v[RAW_WIDTH - 1:0]};
  endfunction : to_raw_width

  // ****************************************************************
  // state
  // ****************************************************************
  sample_set_t samples, next_samples;
  logic new_sample, next_new_sample;
  motion_events_t held, next_held;
  logic [4:0] pending_motion, next_pending_motion;
  logic sample_done_pending, next_sample_done_pending;
  logic [7:0] rd_data_q, next_rd_data;

  motion_events_t picked;
  motion_events_t gated;
  motion_events_t shown;
  logic [4:0] enables;
  logic rd_status;
  logic rd_pending;
  logic [7:0] status_byte;
  logic [7:0] pending_byte;

  // ****************************************************************
  // motion flags
  // ****************************************************************
  // choose source, then gate each flag by its feature enable
  always_comb begin
    picked = UNFILTERED_FLAG_SELECT ? EVENTS_RAW : EVENTS_FILTERED;
    enables[TILT_BIT] = ORIENTATION_DETECT_ON;
    enables[FLIP_BIT] = ORIENTATION_DETECT_ON;
    enables[MOVE_BIT] = MOVEMENT_DETECT_ON;
    enables[SHAKE_BIT] = SHAKE_DETECT_ON;
    enables[TILT35_BIT] = TILT35_DETECT_ON;
    gated = picked & enables;
    // latch keeps a flag up until the feature or the latch is switched off
    if (MOTION_LATCH_ON) begin
      next_held = (held | gated) & enables;
    end else begin
      next_held = gated;
    end
    shown = MOTION_LATCH_ON ? (held | gated) : gated;
  end

  // ****************************************************************
  // samples and new-sample flag
  // ****************************************************************
  assign rd_status = RD_STROBE && (RD_ADDR == MOTION_SAMPLE_FLAGS_ADDR);
  assign rd_pending = RD_STROBE && (RD_ADDR == PENDING_IRQ_FLAGS_ADDR);

  // the whole set is loaded in one edge so reads never mix samples
  always_comb begin
    next_samples = samples;
    next_new_sample = new_sample;
    if (rd_status) begin
      next_new_sample = 1'b0;
    end
    if (SAMPLE_VALID && SAMPLING_ACTIVE) begin
      next_samples = SAMPLE_IN;
      next_new_sample = 1'b1;
      // width chosen at store time; a later mode change leaves the set alone
      if (UNPROCESSED_PASSTHROUGH_SETTING) begin
        next_samples = {to_raw_width(SAMPLE_IN.x_axis_sample),
                        to_raw_width(SAMPLE_IN.y_axis_sample),
                        to_raw_width(SAMPLE_IN.z_axis_sample)};
      end
    end
  end

  // ****************************************************************
  // pending flags
  // ****************************************************************
  // a new event beats the clear of the same read, so nothing is lost
  always_comb begin
    logic [4:0] arm;
    arm = '0;
    arm[TILT_BIT] = IRQ_ENABLE[TILT_BIT] & ORIENTATION_DETECT_ON;
    arm[FLIP_BIT] = IRQ_ENABLE[FLIP_BIT] & ORIENTATION_DETECT_ON;
    arm[MOVE_BIT] = IRQ_ENABLE[MOVE_BIT] & MOVEMENT_DETECT_ON;
    arm[SHAKE_BIT] = IRQ_ENABLE[SHAKE_BIT] & SHAKE_DETECT_ON
                     & MOVEMENT_DETECT_ON;
    arm[TILT35_BIT] = IRQ_ENABLE[TILT35_BIT] & TILT35_DETECT_ON
                      & MOVEMENT_DETECT_ON;
    next_pending_motion = rd_pending ? 5'h00 : pending_motion;
    next_pending_motion = next_pending_motion | (shown & arm);
    next_sample_done_pending = rd_pending ? 1'b0 : sample_done_pending;
    if (SAMPLE_VALID && SAMPLING_ACTIVE && IRQ_ENABLE[NEW_SAMPLE_BIT]) begin
      next_sample_done_pending = 1'b1;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  // reserved bits 5 and 6 are tied low in both status bytes
  always_comb begin
    status_byte = {new_sample, 2'b00, shown};
    pending_byte = {sample_done_pending, 2'b00, pending_motion};
    next_rd_data = rd_data_q;
    if (RD_STROBE) begin
      case (RD_ADDR)
        X_ACCEL_LOW_ADDR: next_rd_data = samples.x_axis_sample[7:0];
        X_ACCEL_HIGH_ADDR: next_rd_data = samples.x_axis_sample[15:8];
        Y_ACCEL_LOW_ADDR: next_rd_data = samples.y_axis_sample[7:0];
        Y_ACCEL_HIGH_ADDR: next_rd_data = samples.y_axis_sample[15:8];
        Z_ACCEL_LOW_ADDR: next_rd_data = samples.z_axis_sample[7:0];
        Z_ACCEL_HIGH_ADDR: next_rd_data = samples.z_axis_sample[15:8];
        MOTION_SAMPLE_FLAGS_ADDR: next_rd_data = status_byte;
        PENDING_IRQ_FLAGS_ADDR: next_rd_data = pending_byte;
        default: next_rd_data = UNMAPPED_READ;
      endcase
    end
  end

  assign RD_DATA = rd_data_q;

  // ****************************************************************
  // registers
  // ****************************************************************
  // synchronous reset; every state bit has a defined value
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      samples <= {SAMPLE_RESET, SAMPLE_RESET, SAMPLE_RESET};
      new_sample <= 1'b0;
      held <= '0;
      pending_motion <= 5'h00;
      sample_done_pending <= 1'b0;
      rd_data_q <= REG_RESET;
    end else begin
      samples <= next_samples;
      new_sample <= next_new_sample;
      held <= next_held;
      pending_motion <= next_pending_motion;
      sample_done_pending <= next_sample_done_pending;
      rd_data_q <= next_rd_data;
    end
  end

endmodule : accel_output_and_event_status

`default_nettype wire
